// >>> ptimer_defs.svh
/*
  Holds the offsets, fields, reset values and mode and pin-function codes of
  the periodic timer; the bus state type is kept in a separate package.
  Assumes an Avalon-MM slave with a 32-bit data word, one register per word.
*/
//
// Behaviour
// - op_mode_sel 00 compare out, 01 capture, 10 pwm/single pulse, 11 timer.
// - timer/counter mode leaves pin level undefined and ignores pin_function_sel.
// - compare-A match in compare mode: 00 hold, 01 low, 10 high, 11 toggle.
// - pwm codes: 00 inactive, 01 active, 10 pwm waveform, 11 single pulse.
// - capture edge: 00 rising, 01 falling, 10 both, 11 capture disabled.
// - counter_on rising edge returns compare-mode pin to its initial level.
// - compare mode: output_initial_level 0 starts low, 1 starts high.
// - pwm mode: output_initial_level 0 active low, 1 active high.
// - single pulse: output_initial_level is the pin level at counter_on rise.
// - output_invert 1 inverts pin; no effect in timer/counter mode (code still drives the pin to output_invert there, oe low).
// - capture_source_sel 0 takes capture input pin, 1 takes clock pin.
// - clear on compare A when 1; else period match, or overflow if period zero.
// - counter_clear_sel has no effect in pwm, single pulse and capture.
// - counter readable only: low byte, bits 9..8 in high byte, rest zero.
// - compare_a and period are 10-bit read/write byte pairs, upper bits zero.
// - compare mode, clear select 0: raise match_a_flag and match_p_flag.
// - compare mode, clear select 1: only match_a_flag, never match_p_flag.
// - compare_a zero: counter overflows at 3FF, no match_a_flag.
// - compare mode: pin changes only on match_a_flag, not on period match.
// - counter_on rise clears counter; fall stops counting, keeps count.
`ifndef PTIMER_DEFS_SVH
`define PTIMER_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define OFS_ON_CTRL    4'h0
`define OFS_MODE_CTRL  4'h1
`define OFS_CNT_LO     4'h2
`define OFS_CNT_HI     4'h3
`define OFS_CMPA_LO    4'h4
`define OFS_CMPA_HI    4'h5
`define OFS_PER_LO     4'h6
`define OFS_PER_HI     4'h7
`define OFS_FLAGS      4'h8
`define OFS_IRQ_EN     4'h9

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define BIT_ON         0
`define BIT_CLK_EXT    1
`define BIT_CLK_FALL   2
`define BIT_CLR_SEL    0
`define BIT_CAP_SRC    1
`define BIT_INVERT     2
`define BIT_INIT_LVL   3
`define FLD_PIN_LO     4
`define FLD_PIN_HI     5
`define FLD_MODE_LO    6
`define FLD_MODE_HI    7
`define BIT_FLAG_A     0
`define BIT_FLAG_P     1
`define BIT_FLAG_CAP   2
`define RST_BYTE       8'h00
`define RST_CNT        10'h000
`define CNT_MAX        10'h3FF

// ----------------------------------------------------------------------------
// mode and pin function codes
// ----------------------------------------------------------------------------
`define MODE_CMP       2'h0
`define MODE_CAP       2'h1
`define MODE_PWM       2'h2
`define MODE_TMR       2'h3
`define PF_00          2'h0
`define PF_01          2'h1
`define PF_10          2'h2
`define PF_11          2'h3

`endif

// >>> ptimer_edge_sync.sv
/*
  Holds the pin synchroniser with edge detection for the external pins.
  Assumes pins are asynchronous to ref_clk; two flops precede any logic.
*/
`timescale 1ns/1ps
module ptimer_edge_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // pin and edges
  input  wire logic pin_async,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // edge flags compare second and third flop only, never the first
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_async;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.sync;
  assign rise  = st_r.sync & ~st_r.last;
  assign fall  = ~st_r.sync & st_r.last;
endmodule

// >>> ptimer_pkg.sv
/*
  Holds the types shared by the timer files.
  Assumes the constants come from ptimer_defs.svh.
*/
package ptimer_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_ACK  = 3'h2,
    BUS_DONE = 3'h4
  } bus_state_t;
endpackage

// >>> periodic_timer.sv
/*
  Holds the 10-bit periodic timer: counter, comparators A and P, the output
  pin logic for compare, pwm and single pulse modes, capture, and the
  Avalon-MM register slave.
  Assumes one 10 MHz clock, synchronous active-high reset, pins asynchronous.
*/
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ptimer_defs.svh"
module periodic_timer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // pins
  input  wire logic        capture_input_pin,
  input  wire logic        timer_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_oe,
  // interrupt request
  output logic             timer_irq
);
  typedef struct packed {
    ptimer_pkg::bus_state_t bus;
    logic [31:0] rdata;
    logic        irq;
    logic        pin_out;
    logic        pin_oe;
    logic [7:0]  on_ctrl;      // bit0 counter_on, bit1 ext clk, bit2 falling
    logic [7:0]  mode_ctrl;
    logic [9:0]  cnt;
    logic [9:0]  cmpa;
    logic [9:0]  per;
    logic [2:0]  flags;
    logic [2:0]  irq_en;
    logic        raw_out;      // output level before polarity
    logic        on_last;
    logic        wreq;         // registered waitrequest
  } tmr_state_t;

  // all timer state in one record: the comb process fills a copy and the
  // clocked process registers it, so every output leaves a flop

  tmr_state_t st_r;
  tmr_state_t st_nxt;

  logic cap_lvl;
  logic cap_rise;
  logic cap_fall;
  logic ck_lvl;
  logic ck_rise;
  logic ck_fall;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  ptimer_edge_sync u_cap_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pin_async (capture_input_pin),
    .level     (cap_lvl),
    .rise      (cap_rise),
    .fall      (cap_fall)
  );

  ptimer_edge_sync u_ck_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pin_async (timer_clock_pin),
    .level     (ck_lvl),
    .rise      (ck_rise),
    .fall      (ck_fall)
  );

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [1:0] mode;
    logic [1:0] pfn;
    logic       init_lvl;
    logic       inv;
    logic       clr_sel;
    logic       on;
    logic       on_rise;
    logic       tick;
    logic       src_rise;
    logic       src_fall;
    logic       cap_hit;
    logic       match_a;
    logic       match_p;
    logic       ovf;
    logic       clr_cnt;
    logic       set_a;
    logic       set_p;
    logic       wr;
    logic [7:0] wb;
    logic       pin_lvl;
    logic [7:0] rb;
    // every local gets a value first, so no path leaves a latch behind
    tick     = 1'b0;
    src_rise = 1'b0;
    src_fall = 1'b0;
    cap_hit  = 1'b0;
    match_a  = 1'b0;
    match_p  = 1'b0;
    ovf      = 1'b0;
    clr_cnt  = 1'b0;
    set_a    = 1'b0;
    set_p    = 1'b0;
    pin_lvl  = 1'b0;

    mode     = st_r.mode_ctrl[`FLD_MODE_HI:`FLD_MODE_LO];
    pfn      = st_r.mode_ctrl[`FLD_PIN_HI:`FLD_PIN_LO];
    init_lvl = st_r.mode_ctrl[`BIT_INIT_LVL];
    inv      = st_r.mode_ctrl[`BIT_INVERT];
    clr_sel  = st_r.mode_ctrl[`BIT_CLR_SEL];
    on       = st_r.on_ctrl[`BIT_ON];
    on_rise  = on & ~st_r.on_last;
    st_nxt   = st_r;
    st_nxt.on_last = on;
    wr       = 1'b0;
    wb       = writedata[7:0];
    rb       = `RST_BYTE;

    // ------------------------------------------------------------------
    // count clock
    // ------------------------------------------------------------------
    // every ref_clk, or a chosen edge of the clock pin
    if (st_r.on_ctrl[`BIT_CLK_EXT]) begin
      tick = st_r.on_ctrl[`BIT_CLK_FALL] ? ck_fall : ck_rise;
    end else begin
      tick = 1'b1;
    end

    // ------------------------------------------------------------------
    // capture source and edge select
    // ------------------------------------------------------------------
    src_rise = st_r.mode_ctrl[`BIT_CAP_SRC] ? ck_rise : cap_rise;
    src_fall = st_r.mode_ctrl[`BIT_CAP_SRC] ? ck_fall : cap_fall;
    case (pfn)
      `PF_00:  cap_hit = src_rise;
      `PF_01:  cap_hit = src_fall;
      `PF_10:  cap_hit = src_rise | src_fall;
      default: cap_hit = 1'b0;
    endcase

    // ------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------
    // a zero compare A never matches, so the count wraps at 3FF
    match_a = on & tick & (st_r.cmpa != 10'h000) & (st_r.cnt == st_r.cmpa);
    match_p = on & tick & (st_r.per != 10'h000) & (st_r.per == st_r.cnt);
    ovf     = on & tick & (st_r.cnt == `CNT_MAX);
    set_a   = 1'b0;
    set_p   = 1'b0;
    clr_cnt = 1'b0;

    // ------------------------------------------------------------------
    // mode logic
    // ------------------------------------------------------------------
    case (mode)
      `MODE_CMP, `MODE_TMR: begin
        if (clr_sel) begin
          clr_cnt = match_a;
          set_a   = match_a;
        end else begin
          clr_cnt = match_p | ((st_r.per == 10'h000) & ovf);
          set_a   = match_a;
          set_p   = match_p;
        end
        if (mode == `MODE_CMP && match_a) begin
          case (pfn)
            `PF_01:  st_nxt.raw_out = 1'b0;
            `PF_10:  st_nxt.raw_out = 1'b1;
            `PF_11:  st_nxt.raw_out = ~st_r.raw_out;
            default: st_nxt.raw_out = st_r.raw_out;
          endcase
        end
      end
      `MODE_CAP: begin
        // capture copies the running count into compare A; clear select unused
        clr_cnt = match_p;
        set_p   = match_p;
        if (on && cap_hit) begin
          st_nxt.cmpa = st_r.cnt;
          st_nxt.flags[`BIT_FLAG_CAP] = 1'b1;
        end
      end
      `MODE_PWM: begin
        if (pfn == `PF_11) begin
          // single pulse: compare A ends the pulse and turns the timer off
          set_a = match_a;
          if (match_a) begin
            st_nxt.on_ctrl[`BIT_ON] = 1'b0;
          end
          if (!on && ck_rise && st_r.on_ctrl[`BIT_CLK_EXT]) begin
            st_nxt.on_ctrl[`BIT_ON] = 1'b1;
          end
        end else begin
          // clear select is ignored: period match or overflow sets the pwm frame
          clr_cnt = match_p | ovf;
          set_a   = match_a;
          set_p   = match_p | ((st_r.per == 10'h000) & ovf);
        end
      end
      default: ;
    endcase

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    if (on_rise) begin
      st_nxt.cnt = `RST_CNT;
    end else if (on && tick) begin
      st_nxt.cnt = clr_cnt ? `RST_CNT : st_r.cnt + 10'h001;
    end

    // ------------------------------------------------------------------
    // output initial level
    // ------------------------------------------------------------------
    // rising counter_on restores the initial output level
    if (on_rise) begin
      st_nxt.raw_out = init_lvl;
    end

    // ------------------------------------------------------------------
    // pin level
    // ------------------------------------------------------------------
    case (mode)
      `MODE_CMP: pin_lvl = st_nxt.raw_out;
      `MODE_PWM: begin
        case (pfn)
          `PF_00: pin_lvl = ~init_lvl;
          `PF_01: pin_lvl = init_lvl;
          `PF_10: pin_lvl = (st_nxt.cnt < st_r.cmpa) ? init_lvl : ~init_lvl;
          default: pin_lvl = st_nxt.on_ctrl[`BIT_ON] ? init_lvl : ~init_lvl;
        endcase
      end
      default: pin_lvl = 1'b0;  // capture and timer: no output function
    endcase
    st_nxt.pin_out = pin_lvl ^ inv;
    // capture and timer modes leave the pin to other functions
    st_nxt.pin_oe  = (mode == `MODE_CMP) | (mode == `MODE_PWM);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // the byte is picked while the request waits in idle and registered,
    // so it already stands in the one cycle that waitrequest is low
    case (address)
      `OFS_ON_CTRL:   rb = {5'h00, st_r.on_ctrl[2:0]};
      `OFS_MODE_CTRL: rb = st_r.mode_ctrl;
      `OFS_CNT_LO:    rb = st_r.cnt[7:0];
      `OFS_CNT_HI:    rb = {6'h00, st_r.cnt[9:8]};
      `OFS_CMPA_LO:   rb = st_r.cmpa[7:0];
      `OFS_CMPA_HI:   rb = {6'h00, st_r.cmpa[9:8]};
      `OFS_PER_LO:    rb = st_r.per[7:0];
      `OFS_PER_HI:    rb = {6'h00, st_r.per[9:8]};
      `OFS_FLAGS:     rb = {5'h00, st_r.flags};
      `OFS_IRQ_EN:    rb = {5'h00, st_r.irq_en};
      default:        rb = `RST_BYTE;
    endcase

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    // idle takes the request, ack answers for one cycle, done lets the
    // master drop its request before the next one can be taken
    st_nxt.rdata = 32'h0000_0000;
    case (st_r.bus)
      ptimer_pkg::BUS_IDLE: begin
        if (read || write) begin
          st_nxt.bus = ptimer_pkg::BUS_ACK;
        end
        if (read) begin
          st_nxt.rdata = {24'h00_0000, rb};
        end
      end
      ptimer_pkg::BUS_ACK: begin
        st_nxt.bus = ptimer_pkg::BUS_DONE;
        wr = write;  // lands at the edge that sees waitrequest low
      end
      ptimer_pkg::BUS_DONE: begin
        st_nxt.bus = ptimer_pkg::BUS_IDLE;
      end
      default: st_nxt.bus = ptimer_pkg::BUS_IDLE;
    endcase
    // waitrequest is registered from the next state, low only in ack
    st_nxt.wreq = (st_nxt.bus != ptimer_pkg::BUS_ACK);


    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // counter bytes are read only
    if (wr) begin
      case (address)
        `OFS_ON_CTRL:   st_nxt.on_ctrl   = {5'h00, wb[2:0]};
        `OFS_MODE_CTRL: st_nxt.mode_ctrl = wb;
        `OFS_CMPA_LO:   st_nxt.cmpa[7:0] = wb;
        `OFS_CMPA_HI:   st_nxt.cmpa[9:8] = wb[1:0];
        `OFS_PER_LO:    st_nxt.per[7:0]  = wb;
        `OFS_PER_HI:    st_nxt.per[9:8]  = wb[1:0];
        `OFS_FLAGS:     st_nxt.flags     = st_r.flags & ~wb[2:0];   // write one to clear
        `OFS_IRQ_EN:    st_nxt.irq_en    = wb[2:0];
        default: ;
      endcase
    end

    // A and P match sets win over a software clear in the same cycle; a flags write drops a capture set
    if (set_a) begin
      st_nxt.flags[`BIT_FLAG_A] = 1'b1;
    end
    if (set_p) begin
      st_nxt.flags[`BIT_FLAG_P] = 1'b1;
    end
    // the request follows only the flags that software has enabled
    st_nxt.irq = |(st_nxt.flags & st_nxt.irq_en);
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r     <= '0;
      st_r.bus <= ptimer_pkg::BUS_IDLE;
      st_r.wreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops; waitrequest is low only in the ack state
  assign readdata         = st_r.rdata;
  assign waitrequest      = st_r.wreq;
  assign timer_output_pin = st_r.pin_out;
  assign timer_output_oe  = st_r.pin_oe;
  assign timer_irq        = st_r.irq;
endmodule

// >>> ptimer_sva.sv
/*
  Holds the concurrent checks on the periodic timer ports.
  Assumes it is bound to periodic_timer; control bytes are shadowed here.
*/
`timescale 1ns/1ps
module ptimer_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // avalon-mm slave
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pin and request
  input wire logic        timer_output_pin,
  input wire logic        timer_output_oe,
  input wire logic        timer_irq
);
  // ---------------------------------------------------------------
  // shadows of what software wrote
  // ---------------------------------------------------------------
  logic [7:0] mode_r;
  logic       on_r;
  logic       ien_r;
  logic [1:0] quiet_r;
  logic       acc;
  logic       on_rise;
  assign acc     = write && !waitrequest;
  assign on_rise = acc && address == 4'h0 && writedata[0] && !on_r;
  // quiet counts edges since a control write, so registered pins have settled
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r  <= 8'h00;
      on_r    <= 1'b0;
      ien_r   <= 1'b0;
      quiet_r <= 2'h0;
    end else begin
      if (acc && address == 4'h1) mode_r <= writedata[7:0];
      if (acc && address == 4'h0) on_r <= writedata[0];
      if (acc && address == 4'h9) ien_r <= writedata[0];
      quiet_r <= (acc && address < 4'h2) ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence
  chk_answer_bound:
    assert property ($rose(read || write) |-> ##[1:3] s_ack)
    else $error("bus request not answered in time");
  chk_upper_zero:
    assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_hi_bits_zero:
    assert property (read && !waitrequest && address inside {4'h3, 4'h5, 4'h7}
                     |-> readdata[7:2] == 6'h00)
    else $error("unused high bits read nonzero");
  chk_oe_mode:
    assert property (quiet_r == 2'h3 |-> timer_output_oe == (mode_r[7:6] inside {2'h0, 2'h2}))
    else $error("output enable does not follow the mode");
  chk_pwm_force:
    assert property (quiet_r == 2'h3 && on_r && mode_r[7:5] == 3'h4
                     |-> timer_output_pin == ((mode_r[4] ? mode_r[3] : !mode_r[3]) ^ mode_r[2]))
    else $error("forced pwm level wrong");
  chk_cmp_hold:
    assert property (quiet_r == 2'h3 && $past(quiet_r) == 2'h3 && mode_r[7:4] == 4'h0
                     |-> $stable(timer_output_pin))
    else $error("pin moved with no-change function");
  chk_init_level:
    assert property (on_rise && mode_r[7:6] == 2'h0
                     |-> ##[1:3] timer_output_pin == (mode_r[3] ^ mode_r[2]))
    else $error("pin not at initial level after start");
  chk_irq_masked:
    assert property (!ien_r && !$past(ien_r) |-> !timer_irq)
    else $error("irq raised while disabled");
endmodule

// >>> ptimer_pins.sv
/*
  Holds a model of the outside logic driving the capture and clock pins.
  Assumes the bench asks for each pin edge with a one-cycle toggle request.
*/
`timescale 1ns/1ps
module ptimer_pins (
  // clock
  input  wire logic ref_clk,
  // toggle requests
  input  wire logic cap_tgl,
  input  wire logic ck_tgl,
  // pins toward the timer
  output logic      cap_pin,
  output logic      ck_pin
);
  initial cap_pin = 1'b0;
  initial ck_pin = 1'b0;
  // pins idle low and move one level per request, after the clock edge
  always @(posedge ref_clk) begin
    cap_pin <= cap_pin ^ cap_tgl;
    ck_pin  <= ck_pin ^ ck_tgl;
  end
endmodule

// >>> tb_top.sv
/*
  Holds the self-checking bench of the periodic timer.
  Assumes ptimer_pins drives the input pins and ptimer_sva is bound below.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest, cap_pin, ck_pin, timer_output_pin, timer_output_oe, timer_irq;
  logic        cap_tgl = 1'b0;
  logic        ck_tgl = 1'b0;
  int          err_total = 0;
  int          check_count = 0;
  int          i;
  logic [7:0]  q, q1;
  row_t rows [16] = '{{4'h1,1'b0,8'h00,8'h00}, {4'h2,1'b0,8'h00,8'h00},
    {4'h3,1'b0,8'h00,8'h00}, {4'h4,1'b0,8'h00,8'h00}, {4'h5,1'b0,8'h00,8'h00},
    {4'h6,1'b0,8'h00,8'h00}, {4'h7,1'b0,8'h00,8'h00}, {4'h4,1'b1,8'hA5,8'hA5},
    {4'h5,1'b1,8'hFF,8'h03}, {4'h6,1'b1,8'h5A,8'h5A}, {4'h7,1'b1,8'hFE,8'h02},
    {4'h2,1'b1,8'h77,8'h00}, {4'h3,1'b1,8'hFF,8'h00}, {4'h1,1'b1,8'hFF,8'hFF},
    {4'hF,1'b1,8'h3C,8'h00}, {4'h1,1'b1,8'h00,8'h00}};
  // 100 ns clock
  always #50 ref_clk = ~ref_clk;
  periodic_timer dut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .capture_input_pin(cap_pin), .timer_clock_pin(ck_pin),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .timer_irq(timer_irq));
  ptimer_pins pins (.ref_clk(ref_clk), .cap_tgl(cap_tgl), .ck_tgl(ck_tgl),
    .cap_pin(cap_pin), .ck_pin(ck_pin));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access; held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    r = readdata[7:0];
    if (n == 20) begin
      err_total++;
      stop_test();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic wr10(input logic [3:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, {6'h00, v[9:8]});
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00, q);
    check("register", q, e);
  endtask
  task automatic pinchk(input logic e);
    check("pin", {7'h00, timer_output_pin}, {7'h00, e});
  endtask
  // one edge on the chosen pin, then time for synchroniser and flag
  task automatic tog(input logic ck);
    if (ck) ck_tgl <= 1'b1;
    else cap_tgl <= 1'b1;
    @(posedge ref_clk);
    ck_tgl <= 1'b0;
    cap_tgl <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic capchk(input logic e);
    bus(4'h8, 1'b0, 8'h00, q);
    check("capture flag", {7'h00, q[2]}, {7'h00, e});
    wr(4'h8, 8'h07);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rdchk(rows[k].a, rows[k].e);
    end
    // compare output: every function, initial level and inversion
    wr10(4'h4, 10'h020);
    wr10(4'h6, 10'h3FF);
    for (i = 0; i < 16; i++) begin
      wr(4'h0, 8'h00);
      wr(4'h1, {2'h0, i[1:0], i[2], i[3], 2'h0});
      wr(4'h0, 8'h01);
      repeat (4) @(posedge ref_clk);
      pinchk(i[2] ^ i[3]);
      repeat (40) @(posedge ref_clk);
      pinchk(((i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h3) ? !i[2] : i[1]) ^ i[3]);
    end
    repeat (1000) @(posedge ref_clk);
    rdchk(4'h8, 8'h03);
    // flags hold while stopped and drive the enabled request
    wr(4'h0, 8'h00);
    wr(4'h9, 8'h01);
    repeat (2) @(posedge ref_clk);
    check("irq", {7'h00, timer_irq}, 8'h01);
    rdchk(4'h8, 8'h03);
    wr(4'h8, 8'h03);
    repeat (2) @(posedge ref_clk);
    check("irq", {7'h00, timer_irq}, 8'h00);
    bus(4'h2, 1'b0, 8'h00, q1);
    repeat (20) @(posedge ref_clk);
    rdchk(4'h2, q1);
    // clear on compare A with period below it: no period flag
    wr10(4'h6, 10'h010);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h01);
    bus(4'h2, 1'b0, 8'h00, q);
    check("restart count", {7'h00, q < 8'h10}, 8'h01);
    repeat (200) @(posedge ref_clk);
    rdchk(4'h8, 8'h01);
    bus(4'h2, 1'b0, 8'h00, q);
    check("count bound", {7'h00, q <= 8'h20}, 8'h01);
    // timer mode, compare A and period zero: overflow, no A flag
    wr(4'h0, 8'h00);
    wr10(4'h4, 10'h000);
    wr10(4'h6, 10'h000);
    wr(4'h1, 8'hC0);
    wr(4'h8, 8'h07);
    wr(4'h0, 8'h01);
    repeat (1100) @(posedge ref_clk);
    bus(4'h8, 1'b0, 8'h00, q);
    check("flag a", {7'h00, q[0]}, 8'h00);
    check("oe", {7'h00, timer_output_oe}, 8'h00);
    // pwm forced levels
    for (i = 0; i < 8; i++) begin
      wr(4'h0, 8'h00);
      wr(4'h1, {3'h4, i[0], i[1], i[2], 2'h0});
      wr(4'h0, 8'h01);
      repeat (4) @(posedge ref_clk);
      pinchk((i[0] ? i[1] : !i[1]) ^ i[2]);
    end
    // capture: every edge code on either source
    for (i = 0; i < 8; i++) begin
      wr(4'h0, 8'h00);
      wr(4'h1, {2'h1, i[1:0], 2'h0, i[2], 1'b0});
      wr(4'h0, 8'h01);
      wr(4'h8, 8'h07);
      tog(!i[2]);
      tog(!i[2]);
      capchk(1'b0);
      tog(i[2]);
      capchk(i[1:0] == 2'h0 || i[1:0] == 2'h2);
      tog(i[2]);
      capchk(i[1:0] == 2'h1 || i[1:0] == 2'h2);
    end
    // pwm waveform: duty above the frame stays active, zero never
    wr(4'h0, 8'h00);
    wr10(4'h6, 10'h020);
    wr10(4'h4, 10'h3FF);
    wr(4'h1, 8'hA8);
    wr(4'h0, 8'h01);
    repeat (40) @(posedge ref_clk);
    pinchk(1'b1);
    wr(4'h0, 8'h00);
    wr10(4'h4, 10'h000);
    wr(4'h0, 8'h01);
    repeat (40) @(posedge ref_clk);
    pinchk(1'b0);
    // single pulse: initial level at start, ended by compare A
    wr(4'h0, 8'h00);
    wr10(4'h4, 10'h010);
    wr(4'h1, 8'hB8);
    wr(4'h0, 8'h01);
    repeat (4) @(posedge ref_clk);
    pinchk(1'b1);
    repeat (40) @(posedge ref_clk);
    pinchk(1'b0);
    rdchk(4'h0, 8'h00);
    stop_test();
  end
endmodule
bind periodic_timer ptimer_sva sva_i (.ref_clk(ref_clk), .reset(reset), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .timer_output_pin(timer_output_pin),
  .timer_output_oe(timer_output_oe), .timer_irq(timer_irq));
